/* File: pkg/tef_pkg.sv */
// package for the transceiver error and status flag block
package tef_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [5:0] ERROR_FLAGS_ADDR = 6'h06;
    localparam logic [5:0] GENERAL_STATUS_ADDR = 6'h07;
    localparam logic [7:0] ERROR_FLAGS_RESET = 8'h00;
    // undefined status bits come out of reset as zero
    localparam logic [7:0] GENERAL_STATUS_RESET = 8'h42;
    localparam logic [6:0] FIFO_DEPTH = 7'h40;
    localparam logic [1:0] FRAMING_ACTIVE = 2'h1;
    // error bit positions
    localparam int BIT_WRITE_ERROR = 7;
    localparam int BIT_OVERHEAT = 6;
    localparam int BIT_FIELD_TIMING = 5;
    localparam int BIT_BUFFER_OVERFLOW = 4;
    localparam int BIT_COLLISION = 3;
    localparam int BIT_CHECKSUM = 2;
    localparam int BIT_ODD_EVEN = 1;
    localparam int BIT_FRAMING_RULE = 0;

    // ----------------------------------------
    // speed codes
    // ----------------------------------------
    typedef enum logic [1:0] {
        SPEED_106 = 2'b00,
        SPEED_212 = 2'b01,
        SPEED_424 = 2'b10,
        SPEED_848 = 2'b11
    } tef_speed_t;

    // events reported by the datapath, one cycle pulses
    typedef struct packed {
        logic host_fifo_write;
        logic internal_fifo_write;
        logic overheat;
        logic field_late;
        logic bit_collision;
        logic checksum_fail;
        logic odd_even_fail;
        logic bad_start_of_frame;
        logic byte_length_violation;
        logic auth_byte_count_bad;
        logic miller_pulse_short;
    } tef_events_t;

    // operating context, levels
    typedef struct packed {
        logic cmd_start;
        logic rx_startup;
        logic auto_anticollision_cmd;
        logic authentication_cmd;
        logic awaiting_reply;
        logic initiator;
        logic active_mode;
        logic card_scheme_a;
        logic sync_detect_enable;
        logic receive_checksum_enable;
        logic [1:0] receive_framing_sel;
        logic [1:0] transmit_framing_sel;
        tef_speed_t speed;
        logic temp_clear;
        logic temp_below_limit;
    } tef_ctx_t;
endpackage

/* File: verilog/tef_read_port.sv */
// registered read port for the two flag registers
`timescale 1ns/1ns
`default_nettype none
module tef_read_port
    import tef_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // register sources
    input wire logic [5:0] i_addr,
    input wire logic i_rd,
    input wire logic [7:0] i_error_flags,
    input wire logic [7:0] i_general_status,
    // read data
    output logic [7:0] o_rdata
);
    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = o_rdata;
        if (i_rd) begin
            case (i_addr)
                ERROR_FLAGS_ADDR: next_rdata = i_error_flags;
                GENERAL_STATUS_ADDR: next_rdata = i_general_status;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= next_rdata;
        end
    end
endmodule
`default_nettype wire

/* File: verilog/tef_flags.sv */
// error flag register and general status register
// Functional notes
// - fifo write during busy phases sets write error
// - overheat sets flag, antenna drivers off
// - late field in active mode, framing 01
// - write into full fifo sets overflow
// - collision at 106; forced one otherwise outside startup
// - checksum fail with check enabled; startup clears
// - parity fail at 106 type a or active mode; startup clears
// - bad start of frame at 106
// - anticollision while initiator sets framing error
// - wrong byte count in authentication
// - short miller pulse spacing sets framing error
// - command start clears all but overheat
// - reset zero, read only, fixed order
// - status reset values fixed
// - any error raises error interrupt request
// - high watermark when 64 minus level small
// - interrupt pending from enabled sources
`timescale 1ns/1ns
`default_nettype none
module tef_flags
    import tef_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // datapath events and context
    input wire tef_events_t i_ev,
    input wire tef_ctx_t i_ctx,
    input wire logic i_fifo_full,
    input wire logic [6:0] i_fifo_fill_level,
    input wire logic [5:0] i_watermark_threshold,
    // other status sources
    input wire logic i_carrier_frequency_ok,
    input wire logic i_checksum_good,
    input wire logic i_checksum_done,
    input wire logic i_timer_active,
    input wire logic i_field_present,
    input wire logic i_other_irq_pending,
    input wire logic i_error_irq_enable,
    // host read port
    input wire logic [5:0] i_addr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // outputs
    output logic [7:0] o_error_flags,
    output logic [7:0] o_general_status,
    output logic o_error_interrupt_request,
    output logic o_antenna_off
);
    // ----------------------------------------
    // error flags
    // ----------------------------------------
    logic [7:0] error_flags;
    logic [7:0] next_error_flags;
    logic [7:0] set_v;
    logic at_106;

    function automatic logic is_106(input tef_speed_t s);
        return s == SPEED_106;
    endfunction

    always_comb begin
        at_106 = is_106(i_ctx.speed);
        set_v = 8'h00;
        set_v[BIT_WRITE_ERROR] = i_ev.host_fifo_write && (i_ctx.auto_anticollision_cmd
            || i_ctx.authentication_cmd || i_ctx.awaiting_reply);
        set_v[BIT_OVERHEAT] = i_ev.overheat;
        set_v[BIT_FIELD_TIMING] = i_ev.field_late && i_ctx.active_mode
            && (i_ctx.receive_framing_sel == FRAMING_ACTIVE
            || i_ctx.transmit_framing_sel == FRAMING_ACTIVE);
        set_v[BIT_BUFFER_OVERFLOW] = i_fifo_full
            && (i_ev.host_fifo_write || i_ev.internal_fifo_write);
        set_v[BIT_COLLISION] = (i_ev.bit_collision && at_106)
            || (!at_106 && !i_ctx.rx_startup);
        set_v[BIT_CHECKSUM] = i_ev.checksum_fail && i_ctx.receive_checksum_enable;
        set_v[BIT_ODD_EVEN] = i_ev.odd_even_fail && at_106
            && (i_ctx.card_scheme_a || i_ctx.active_mode);
        set_v[BIT_FRAMING_RULE] = (i_ev.bad_start_of_frame && at_106)
            || (i_ev.byte_length_violation && i_ctx.sync_detect_enable
                && !at_106)
            || (i_ctx.auto_anticollision_cmd && i_ctx.initiator)
            || (i_ev.auth_byte_count_bad && i_ctx.authentication_cmd)
            || i_ev.miller_pulse_short;
    end

    always_comb begin
        next_error_flags = error_flags;
        // command start clears, overheat excepted; hardware sets still win
        if (i_ctx.cmd_start) begin
            next_error_flags = error_flags & 8'h40;
        end
        // startup clears before this cycle's sets so new errors survive
        if (i_ctx.rx_startup) begin
            next_error_flags[BIT_COLLISION] = 1'b0;
            next_error_flags[BIT_CHECKSUM] = 1'b0;
            next_error_flags[BIT_ODD_EVEN] = 1'b0;
            next_error_flags[BIT_FRAMING_RULE] = 1'b0;
        end
        // overheat only leaves through the explicit clear below the limit
        if (i_ctx.temp_clear && i_ctx.temp_below_limit) begin
            next_error_flags[BIT_OVERHEAT] = 1'b0;
        end
        next_error_flags = next_error_flags | set_v;
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            error_flags <= ERROR_FLAGS_RESET;
        end else begin
            error_flags <= next_error_flags;
        end
    end

    // ----------------------------------------
    // status
    // ----------------------------------------
    logic [7:0] next_status;
    logic [6:0] free_space;

    always_comb begin
        free_space = FIFO_DEPTH - i_fifo_fill_level;
        next_status = {i_carrier_frequency_ok, i_checksum_good, i_checksum_done,
            (i_other_irq_pending || (|error_flags && i_error_irq_enable)),
            i_timer_active, i_field_present,
            (free_space <= {1'b0, i_watermark_threshold}),
            (i_fifo_fill_level <= {1'b0, i_watermark_threshold})};
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_general_status <= GENERAL_STATUS_RESET;
            o_antenna_off <= 1'b0;
        end else begin
            o_general_status <= next_status;
            o_antenna_off <= next_error_flags[BIT_OVERHEAT];
        end
    end

    assign o_error_flags = error_flags;
    assign o_error_interrupt_request = |error_flags;

    // ----------------------------------------
    // host read port; no write path exists, so software cannot set flags
    // ----------------------------------------
    tef_read_port tef_read_port_i (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_addr(i_addr),
        .i_rd(i_rd),
        .i_error_flags(error_flags),
        .i_general_status(o_general_status),
        .o_rdata(o_rdata)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_overflow_set: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_fifo_full && i_ev.host_fifo_write |=> error_flags[BIT_BUFFER_OVERFLOW])
        else $error("overflow not flagged");
    a_write_err_set: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_ev.host_fifo_write && i_ctx.awaiting_reply |=> error_flags[BIT_WRITE_ERROR])
        else $error("write error not flagged");
    a_overheat_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        error_flags[BIT_OVERHEAT] && !i_ctx.temp_clear |=> error_flags[BIT_OVERHEAT])
        else $error("overheat flag lost");
    a_antenna_off: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_ev.overheat |=> o_antenna_off && error_flags[BIT_OVERHEAT])
        else $error("antenna not switched off");
    a_cmd_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_ctx.cmd_start && set_v == 8'h00 && !i_ctx.temp_clear
        |=> error_flags == ($past(error_flags) & 8'h40))
        else $error("command start clear wrong");
    a_err_irq: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        o_error_interrupt_request == (error_flags != 8'h00))
        else $error("error request mismatch");
    a_collision_force: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        !at_106 && !i_ctx.rx_startup |=> error_flags[BIT_COLLISION])
        else $error("collision not forced");
    a_startup_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_ctx.rx_startup && !i_ev.checksum_fail |=> !error_flags[BIT_CHECKSUM])
        else $error("checksum error not cleared");
    a_high_mark: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_fifo_fill_level == 7'h3c && i_watermark_threshold == 6'h04
        |=> o_general_status[1])
        else $error("high watermark wrong");
    a_field_timing: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_ev.field_late && i_ctx.active_mode && i_ctx.receive_framing_sel == FRAMING_ACTIVE
        |=> error_flags[BIT_FIELD_TIMING])
        else $error("field timing error not flagged");
    a_overflow_internal: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_fifo_full && i_ev.internal_fifo_write
        |=> error_flags[BIT_BUFFER_OVERFLOW])
        else $error("internal overflow not flagged");
    a_collision_set: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_ev.bit_collision && i_ctx.speed == SPEED_106
        |=> error_flags[BIT_COLLISION])
        else $error("collision not flagged");
    a_checksum_set: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_ev.checksum_fail && i_ctx.receive_checksum_enable
        |=> error_flags[BIT_CHECKSUM])
        else $error("checksum error not flagged");
    a_parity_set: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_ev.odd_even_fail && i_ctx.speed == SPEED_106 && i_ctx.card_scheme_a
        |=> error_flags[BIT_ODD_EVEN])
        else $error("parity error not flagged");
    a_sof_set: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_ev.bad_start_of_frame && i_ctx.speed == SPEED_106
        |=> error_flags[BIT_FRAMING_RULE])
        else $error("start of frame error not flagged");
    a_sync_length: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_ev.byte_length_violation && i_ctx.sync_detect_enable && i_ctx.speed != SPEED_106
        |=> error_flags[BIT_FRAMING_RULE])
        else $error("byte length error not flagged");
    a_initiator_coll: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_ctx.auto_anticollision_cmd && i_ctx.initiator
        |=> error_flags[BIT_FRAMING_RULE])
        else $error("initiator anticollision not flagged");
    a_auth_count: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_ev.auth_byte_count_bad && i_ctx.authentication_cmd
        |=> error_flags[BIT_FRAMING_RULE])
        else $error("authentication count not flagged");
    a_miller_short: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_ev.miller_pulse_short |=> error_flags[BIT_FRAMING_RULE])
        else $error("short pulse spacing not flagged");
    a_rdata_flags: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_rd && i_addr == ERROR_FLAGS_ADDR |=> o_rdata == $past(error_flags))
        else $error("error register read wrong");
    a_set_irq: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        set_v != 8'h00 |=> o_error_interrupt_request)
        else $error("error request not raised");
    a_status_irq: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        (|error_flags) && i_error_irq_enable |=> o_general_status[4])
        else $error("interrupt pending not shown");
    a_startup_first: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_ctx.rx_startup && !i_ev.bit_collision && i_ctx.speed == SPEED_106
        |=> !error_flags[BIT_COLLISION])
        else $error("collision not cleared at startup");
endmodule
`default_nettype wire

/* File: verification/tef_host_model.sv */
// host controller model that issues register reads
`timescale 1ns/1ns
`default_nettype none
module tef_host_model (
    // clock
    input wire logic i_sys_clk,
    // read port
    input wire logic [7:0] i_rdata,
    output logic [5:0] o_addr,
    output logic o_rd
);
    initial begin
        o_addr = 6'h00;
        o_rd = 1'b0;
    end
    // strobe held over one edge; data taken only once that edge has landed
    task automatic read(input logic [5:0] addr, output logic [7:0] data);
        @(posedge i_sys_clk);
        o_addr <= addr;
        o_rd <= 1'b1;
        @(posedge i_sys_clk);
        o_rd <= 1'b0;
        @(negedge i_sys_clk);
        data = i_rdata;
    endtask
endmodule
`default_nettype wire

/* File: verification/tef_tb_top.sv */
// self-checking bench for the error and status flag block
`timescale 1ns/1ns
`default_nettype none
module transceiver_error_status_flags_tb_top
    import tef_pkg::*;
;
    typedef struct packed {
        tef_events_t ev;
        tef_ctx_t ctx;
        logic full;
        logic [7:0] exp;
    } tef_row_t;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    tef_events_t ev = '0;
    tef_ctx_t ctx = '0;
    logic full = 1'b0;
    logic [6:0] fill = 7'h00;
    logic [5:0] thr = 6'h04;
    logic [4:0] src = 5'h00;
    logic other = 1'b0;
    logic irq_en = 1'b0;
    logic [5:0] addr;
    logic rd;
    logic [7:0] rdata, flags, status, data;
    logic irq, ant;
    int miscompares = 0;
    int checked = 0;
    // ----------------------------------------
    // ordinary cases: event, context, fifo full, expected flags
    // ----------------------------------------
    tef_row_t rows [22] = '{
        '{11'h400, 18'h08000, 1'b0, 8'h80}, '{11'h400, 18'h04000, 1'b0, 8'h80},
        '{11'h400, 18'h02000, 1'b0, 8'h80}, '{11'h400, 18'h00000, 1'b0, 8'h00},
        '{11'h080, 18'h00840, 1'b0, 8'h20}, '{11'h080, 18'h00810, 1'b0, 8'h20},
        '{11'h080, 18'h00800, 1'b0, 8'h00}, '{11'h400, 18'h00000, 1'b1, 8'h10},
        '{11'h200, 18'h00000, 1'b1, 8'h10}, '{11'h040, 18'h00000, 1'b0, 8'h08},
        '{11'h020, 18'h00100, 1'b0, 8'h04}, '{11'h020, 18'h00000, 1'b0, 8'h00},
        '{11'h010, 18'h00400, 1'b0, 8'h02}, '{11'h008, 18'h00000, 1'b0, 8'h01},
        '{11'h004, 18'h00204, 1'b0, 8'h09}, '{11'h000, 18'h09000, 1'b0, 8'h01},
        '{11'h010, 18'h00800, 1'b0, 8'h02}, '{11'h004, 18'h00200, 1'b0, 8'h00},
        '{11'h000, 18'h00008, 1'b0, 8'h08}, '{11'h040, 18'h1000c, 1'b0, 8'h00},
        '{11'h002, 18'h04000, 1'b0, 8'h01}, '{11'h001, 18'h00400, 1'b0, 8'h01}
    };
    always #50 clk = ~clk;
    tef_flags tef_flags_i (
        .i_sys_clk(clk), .i_rstn(rstn), .i_ev(ev), .i_ctx(ctx), .i_fifo_full(full),
        .i_fifo_fill_level(fill), .i_watermark_threshold(thr),
        .i_carrier_frequency_ok(src[4]), .i_checksum_good(src[3]), .i_checksum_done(src[2]),
        .i_timer_active(src[1]), .i_field_present(src[0]), .i_other_irq_pending(other),
        .i_error_irq_enable(irq_en), .i_addr(addr), .i_rd(rd), .o_rdata(rdata),
        .o_error_flags(flags), .o_general_status(status),
        .o_error_interrupt_request(irq), .o_antenna_off(ant)
    );
    tef_host_model tef_host_model_i (.i_sys_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_rd(rd));
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one cycle of events and context, then back to quiet
    task automatic pulse(input tef_events_t e, input tef_ctx_t c, input logic f);
        @(posedge clk);
        ev <= e;
        ctx <= c;
        full <= f;
        @(posedge clk);
        ev <= '0;
        ctx <= '0;
        full <= 1'b0;
        @(negedge clk);
    endtask
    task automatic stat(input logic [6:0] fl, input logic [4:0] s, input logic o, input logic en,
                        input logic [7:0] exp);
        @(posedge clk);
        fill <= fl;
        src <= s;
        other <= o;
        irq_en <= en;
        repeat (2) @(posedge clk);
        tef_host_model_i.read(GENERAL_STATUS_ADDR, data);
        check("status", exp, status);
        check("status_rd", exp, data);
    endtask
    task automatic final_report();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // hang guard, far beyond the real run length
    initial begin
        #2000000;
        miscompares++;
        final_report();
    end
    initial begin
        @(negedge clk);
        check("flags_rst", 8'h00, flags);
        check("status_rst", 8'h42, status & 8'h76);
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        for (int k = 0; k < 22; k++) begin
            pulse('0, 18'h30000, 1'b0);
            pulse(rows[k].ev, rows[k].ctx, rows[k].full);
            check("flags", rows[k].exp, flags);
            check("irq", {7'h00, |rows[k].exp}, {7'h00, irq});
            tef_host_model_i.read(ERROR_FLAGS_ADDR, data);
            check("rdata", rows[k].exp, data);
        end
        stat(7'd60, 5'h15, 1'b0, 1'b0, 8'ha6);
        stat(7'd59, 5'h15, 1'b0, 1'b0, 8'ha4);
        stat(7'd4, 5'h15, 1'b0, 1'b0, 8'ha5);
        stat(7'd5, 5'h0a, 1'b1, 1'b0, 8'h58);
        stat(7'd5, 5'h0a, 1'b0, 1'b1, 8'h58);
        stat(7'd5, 5'h0a, 1'b0, 1'b0, 8'h48);
        // second threshold, so the comparison does not hinge on one value
        @(posedge clk);
        thr <= 6'h08;
        stat(7'd56, 5'h15, 1'b0, 1'b0, 8'ha6);
        stat(7'd55, 5'h15, 1'b0, 1'b0, 8'ha4);
        stat(7'd8, 5'h15, 1'b0, 1'b0, 8'ha5);
        tef_host_model_i.read(6'h05, data);
        check("unmapped", 8'h00, data);
        // overheat survives command start and a clear above the limit
        pulse('0, 18'h30000, 1'b0);
        pulse(11'h100, '0, 1'b0);
        check("overheat", 8'h40, flags);
        check("antenna", 8'h01, {7'h00, ant});
        pulse('0, 18'h20000, 1'b0);
        check("hold_cmd", 8'h40, flags);
        pulse('0, 18'h00002, 1'b0);
        check("hold_hot", 8'h40, flags);
        pulse('0, 18'h00003, 1'b0);
        check("cooled", 8'h00, flags);
        check("antenna_on", 8'h00, {7'h00, ant});
        // startup clear must not swallow an error of the same reception
        pulse(11'h040, '0, 1'b0);
        pulse(11'h020, 18'h10100, 1'b0);
        check("startup", 8'h04, flags);
        pulse(11'h100, '0, 1'b0);
        @(posedge clk);
        rstn <= 1'b0;
        @(negedge clk);
        check("flags_rst2", 8'h00, flags);
        check("status_rst2", 8'h42, status & 8'h76);
        check("antenna_rst", 8'h00, {7'h00, ant});
        @(posedge clk);
        rstn <= 1'b1;
        final_report();
    end
endmodule
`default_nettype wire
